// file: design/tweecp_device.sv
/*
 * eeprom end of the three-wire link: instruction decoder, 64 x 16
 * array, programming lock and self-timed busy cycle with status.
 * assumes the link clock stands still outside frames; the busy timer
 * runs on the free 10 MHz clock; rst_n stands for power-up.
 */
`timescale 1ns/1ps
`include "tweecp_consts.svh"
module tweecp_device #(
   parameter logic [`TWEECP_TMR_W-1:0] WP_CYCLES = `TWEECP_TMR_W'(`TWEECP_WP_CYCLES)
) (
   input wire logic clock,
   input wire logic rst_n,
   tweecp_if.dev link,
   output logic busy,
   output logic unlocked
);
   import tweecp_pkg::*;

   tweecp_dlink_t s;
   tweecp_dlink_t next_s;
   tweecp_dcore_t c;
   tweecp_dcore_t next_c;
   logic fresh;
   logic frame_rst_n;
   logic tgl_s;
   logic cs_s;
   tweecp_link_t ph_eff;
   logic [7:0] hdr_w;
   logic [`TWEECP_DW-1:0] word_w;
   logic [1:0] op_w;
   logic [`TWEECP_AW-1:0] addr_w;

   // ----------------------------------------------------------------
   // frame marker on the link clock
   // ----------------------------------------------------------------
   // held set while select is low, cleared by the first shift edge
   assign frame_rst_n = rst_n & link.cs;
   always_ff @(posedge link.shift_clock or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         fresh <= 1'b1;
      end else begin
         fresh <= 1'b0; // [RULE1]
      end
   end

   // ----------------------------------------------------------------
   // link side: shifter, decoder and array
   // ----------------------------------------------------------------
   // assembled fields of the current edge
   assign hdr_w = {s.hdr[6:0], link.serial_in};
   assign word_w = {s.data[`TWEECP_DW-2:0], link.serial_in};
   assign op_w = hdr_w[7:6];
   assign addr_w = hdr_w[`TWEECP_AW-1:0];
   assign ph_eff = fresh ? LK_START : s.ph;

   // next link state, taken on each rising shift edge
   always_comb begin
      next_s = s;
      if (link.cs) begin // [RULE18]
         if (fresh) begin
            next_s.reading = 1'b0;
         end
         unique case (ph_eff)
            LK_START: begin
               // leading zeros are skipped until the start marker
               if (link.serial_in) begin // [RULE1]
                  next_s.ph = LK_HDR;
                  next_s.cnt = 5'h00;
               end else begin
                  next_s.ph = LK_START;
               end
            end
            LK_HDR: begin
               next_s.hdr = hdr_w; // [RULE1]
               next_s.cnt = s.cnt + 5'h01;
               if (s.cnt == `TWEECP_HDR_LAST) begin
                  next_s.ph = LK_DONE;
                  next_s.cnt = 5'h00;
                  unique case (op_w)
                     `TWEECP_OP_READ: begin
                        // dummy zero first, then the word
                        next_s.data = s.mem[addr_w]; // [RULE16]
                        next_s.out = 1'b0; // [RULE6]
                        next_s.reading = 1'b1;
                        next_s.ph = LK_READ;
                     end
                     `TWEECP_OP_ERASE: begin
                        // erase starts as soon as address is in
                        if (s.unlocked) begin // [RULE7]
                           next_s.mem[addr_w] = `TWEECP_ERASED; // [RULE9]
                           next_s.tgl = ~s.tgl;
                        end
                     end
                     `TWEECP_OP_WRITE: begin
                        next_s.ph = LK_DATA; // [RULE2]
                     end
                     `TWEECP_OP_SPECIAL: begin
                        unique case (addr_w[`TWEECP_AW-1:`TWEECP_AW-2]) // [RULE3]
                           `TWEECP_SUB_UNLOCK: begin
                              next_s.unlocked = 1'b1; // [RULE8]
                           end
                           `TWEECP_SUB_LOCK: begin
                              next_s.unlocked = 1'b0; // [RULE4]
                           end
                           `TWEECP_SUB_ERASE_ALL: begin
                              if (s.unlocked) begin // [RULE7]
                                 for (int i = 0; i < `TWEECP_WORDS; i++) begin
                                    next_s.mem[i] = `TWEECP_ERASED; // [RULE14]
                                 end
                                 next_s.tgl = ~s.tgl;
                              end
                           end
                           `TWEECP_SUB_WRITE_ALL: begin
                              next_s.ph = LK_DATA; // [RULE15]
                           end
                        endcase
                     end
                  endcase
               end
            end
            LK_DATA: begin
               next_s.data = word_w;
               next_s.cnt = s.cnt + 5'h01;
               if (s.cnt == `TWEECP_DATA_LAST) begin
                  // programming begins after the last data bit
                  next_s.ph = LK_DONE;
                  if (s.unlocked) begin // [RULE7]
                     if (s.hdr[7:6] == `TWEECP_OP_WRITE) begin
                        next_s.mem[s.hdr[`TWEECP_AW-1:0]] = word_w; // [RULE10]
                     end else begin
                        for (int i = 0; i < `TWEECP_WORDS; i++) begin
                           next_s.mem[i] = word_w; // [RULE15]
                        end
                     end
                     next_s.tgl = ~s.tgl;
                  end
               end
            end
            LK_READ: begin
               // one bit per rising edge, msb first
               if (s.cnt == `TWEECP_READ_END) begin
                  next_s.reading = 1'b0;
                  next_s.ph = LK_DONE;
               end else begin
                  next_s.out = s.data[`TWEECP_DW-1]; // [RULE5]
                  next_s.data = {s.data[`TWEECP_DW-2:0], 1'b0};
                  next_s.cnt = s.cnt + 5'h01;
               end
            end
            LK_DONE: begin
               next_s.ph = LK_DONE;
            end
            default: begin
               next_s.ph = LK_DONE;
            end
         endcase
      end
   end

   // link register; array and lock only lose state at power-up
   always_ff @(posedge link.shift_clock or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0; // [RULE7]
      end else begin
         s <= next_s;
      end
   end

   // ----------------------------------------------------------------
   // crossings into the system clock
   // ----------------------------------------------------------------
   tweecp_sync u_tgl_sync (
      .clock(clock),
      .rst_n(rst_n),
      .d(s.tgl),
      .q(tgl_s)
   );

   tweecp_sync u_cs_sync (
      .clock(clock),
      .rst_n(rst_n),
      .d(link.cs),
      .q(cs_s)
   );

   // ----------------------------------------------------------------
   // self-timed cycle and status window
   // ----------------------------------------------------------------
   // a toggle starts the timer; select rising while busy opens status
   always_comb begin
      next_c = c;
      next_c.tgl_seen = tgl_s;
      next_c.cs_prev = cs_s;
      if (tgl_s != c.tgl_seen) begin
         next_c.busy = 1'b1; // [RULE9]
         next_c.timer = WP_CYCLES - `TWEECP_TMR_W'(1);
      end else if (c.busy) begin
         if (c.timer == '0) begin
            next_c.busy = 1'b0;
         end else begin
            next_c.timer = c.timer - `TWEECP_TMR_W'(1);
         end
      end
      if (!cs_s) begin
         next_c.show = 1'b0;
      end else if (!c.cs_prev && c.busy) begin
         next_c.show = 1'b1; // [RULE13]
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         c <= '0;
      end else begin
         c <= next_c;
      end
   end

   // ----------------------------------------------------------------
   // output pin
   // ----------------------------------------------------------------
   // status before the first edge of a frame, read data after
   assign link.dout = fresh ? ~c.busy : s.out; // [RULE12]
   assign link.dout_oe = link.cs & (fresh ? c.show : s.reading); // [RULE19]
   assign busy = c.busy;
   assign unlocked = s.unlocked;
endmodule : tweecp_device

// file: design/tweecp_consts.svh
/*
 * constants of the three-wire eeprom command port: sizes, opcodes,
 * special sub-codes and timing counts.
 * assumes a 10 MHz system clock; included by both ends.
 */
// Functional notes
// RULE1: frame opens on select rise: start, opcode, address
// RULE2: read 10, write 01, erase 11, then address
// RULE3: opcode 00: 11 unlock, 10 erase all, 01 write all
// RULE4: opcode 00 with 00 locks programming
// RULE5: read drives word out on shift rising edges
// RULE6: read sends zero dummy bit, then 16 bits
// RULE7: power-up locked; erase and write ignored until unlocked
// RULE8: unlock holds until lock command or power loss
// RULE9: erase sets word to ones, starts when decoded
// RULE10: write takes 16 bits, timing starts after last
// RULE11: host holds select low 250 ns before status
// RULE12: status low while busy, high when ready
// RULE13: no status if select rises after cycle ends
// RULE14: erase all sets array to ones, reports status
// RULE15: write all fills array with word, reports status
// RULE16: read works whether locked or unlocked
// RULE17: host gives nine shift clocks for short commands
// RULE18: input sampled on rising shift edge, select high
// RULE19: output released while select low, else driven selectively
`ifndef TWEECP_CONSTS_SVH
`define TWEECP_CONSTS_SVH

// ----------------------------------------------------------------
// array shape and instruction fields
// ----------------------------------------------------------------
`define TWEECP_WORDS 64
`define TWEECP_AW 6
`define TWEECP_DW 16
`define TWEECP_ERASED 16'hffff
`define TWEECP_OP_SPECIAL 2'h0
`define TWEECP_OP_WRITE 2'h1
`define TWEECP_OP_READ 2'h2
`define TWEECP_OP_ERASE 2'h3
`define TWEECP_SUB_LOCK 2'h0
`define TWEECP_SUB_WRITE_ALL 2'h1
`define TWEECP_SUB_ERASE_ALL 2'h2
`define TWEECP_SUB_UNLOCK 2'h3
`define TWEECP_HDR_LAST 5'h07
`define TWEECP_DATA_LAST 5'h0f
`define TWEECP_READ_END 5'h10

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define TWEECP_CLK_HZ 10000000
`define TWEECP_CLK_NS 100
`define TWEECP_T_WP_MS 10
`define TWEECP_WP_CYCLES (`TWEECP_T_WP_MS * `TWEECP_CLK_HZ / 1000)
`define TWEECP_TMR_W 17
`define TWEECP_T_CS_NS 250
`define TWEECP_CS_CYCLES ((`TWEECP_T_CS_NS + `TWEECP_CLK_NS - 1) / `TWEECP_CLK_NS)
`define TWEECP_SHIFT_HALF 3'h4
`define TWEECP_SETTLE 4'h8
`define TWEECP_RISES_SHORT 5'h09
`define TWEECP_RISES_WRITE 5'h19
`define TWEECP_RISES_READ 5'h1a
`define TWEECP_RD_FIRST 5'h0a

`endif

// file: design/tweecp_pkg.sv
/*
 * types of the three-wire eeprom command port: states, commands and
 * the state records of both ends.
 * assumes tweecp_consts.svh is reachable by include path.
 */
`include "tweecp_consts.svh"
package tweecp_pkg;

   // ----------------------------------------------------------------
   // enumerations
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      LK_START = 3'h0, LK_HDR = 3'h1, LK_DATA = 3'h2, LK_READ = 3'h3, LK_DONE = 3'h4
   } tweecp_link_t;

   typedef enum logic [2:0] {
      H_IDLE = 3'h0, H_SHIFT = 3'h1, H_GAP = 3'h2, H_SETTLE = 3'h3, H_POLL = 3'h4
   } tweecp_hst_t;

   typedef enum logic [2:0] {
      CMD_READ = 3'h0, CMD_WRITE = 3'h1, CMD_ERASE = 3'h2, CMD_UNLOCK = 3'h3,
      CMD_LOCK = 3'h4, CMD_ERASE_ALL = 3'h5, CMD_WRITE_ALL = 3'h6
   } tweecp_cmd_t;

   // ----------------------------------------------------------------
   // state records
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [`TWEECP_WORDS-1:0][`TWEECP_DW-1:0] mem;
      logic unlocked;
      tweecp_link_t ph;
      logic [4:0] cnt;
      logic [7:0] hdr;
      logic [`TWEECP_DW-1:0] data;
      logic out;
      logic reading;
      logic tgl;
   } tweecp_dlink_t;

   typedef struct packed {
      logic tgl_seen;
      logic busy;
      logic [`TWEECP_TMR_W-1:0] timer;
      logic cs_prev;
      logic show;
   } tweecp_dcore_t;

   typedef struct packed {
      tweecp_hst_t st;
      logic [2:0] div;
      logic shift_clk;
      logic cs;
      logic sdata;
      logic [25:0] sh;
      logic [4:0] nb;
      logic [4:0] total;
      logic rd;
      logic prog;
      logic [3:0] wcnt;
      logic [`TWEECP_DW-1:0] rx;
      logic rsp_valid;
      logic [`TWEECP_DW-1:0] rsp_data;
   } tweecp_host_t;

endpackage : tweecp_pkg

// file: design/tweecp_if.sv
/*
 * three-wire link between the host end and the eeprom end.
 * assumes a pull-up on the serial output wire while nobody drives it.
 */
`timescale 1ns/1ps
interface tweecp_if;
   logic cs;
   logic shift_clock;
   logic serial_in;
   logic dout;
   logic dout_oe;
   logic serial_out;

   // resolved wire level, pull-up when released
   assign serial_out = dout_oe ? dout : 1'b1;

   modport dev (input cs, input shift_clock, input serial_in, output dout, output dout_oe);
   modport host (output cs, output shift_clock, output serial_in, input serial_out);
endinterface : tweecp_if

// file: design/tweecp_sync.sv
/*
 * two-flop level synchroniser.
 * assumes d is a slow level from another clock domain.
 */
`timescale 1ns/1ps
module tweecp_sync (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic d,
   output logic q
);
   logic [1:0] stg;

   // ----------------------------------------------------------------
   // two stages; only the second is read outside
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         stg <= 2'h0;
      end else begin
         stg <= {stg[0], d};
      end
   end
   assign q = stg[1];
endmodule : tweecp_sync

// file: design/tweecp_host.sv
/*
 * host end of the three-wire link: frames one command at a time,
 * makes the shift clock by division, reads words and waits on status.
 * assumes the command port is on the same 10 MHz clock.
 */
`timescale 1ns/1ps
`include "tweecp_consts.svh"
module tweecp_host (
   input wire logic clock,
   input wire logic rst_n,
   tweecp_if.host link,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire tweecp_pkg::tweecp_cmd_t cmd_op,
   input wire logic [`TWEECP_AW-1:0] cmd_addr,
   input wire logic [`TWEECP_DW-1:0] cmd_data,
   output logic rsp_valid,
   output logic [`TWEECP_DW-1:0] rsp_data
);
   import tweecp_pkg::*;

   tweecp_host_t h;
   tweecp_host_t next_h;
   logic so_s;
   logic [1:0] opc;
   logic [`TWEECP_AW-1:0] adr;
   logic [4:0] tot;
   logic prg;

   tweecp_sync u_so_sync (
      .clock(clock),
      .rst_n(rst_n),
      .d(link.serial_out),
      .q(so_s)
   );

   // ----------------------------------------------------------------
   // command to instruction fields
   // ----------------------------------------------------------------
   always_comb begin
      opc = `TWEECP_OP_SPECIAL;
      adr = cmd_addr;
      tot = `TWEECP_RISES_SHORT; // [RULE17]
      prg = 1'b1;
      unique case (cmd_op)
         CMD_READ: begin
            opc = `TWEECP_OP_READ;
            tot = `TWEECP_RISES_READ;
            prg = 1'b0;
         end
         CMD_WRITE: begin
            opc = `TWEECP_OP_WRITE;
            tot = `TWEECP_RISES_WRITE;
         end
         CMD_ERASE: opc = `TWEECP_OP_ERASE; // [RULE2]
         CMD_UNLOCK: begin
            adr = {`TWEECP_SUB_UNLOCK, 4'h0}; // [RULE3]
            prg = 1'b0;
         end
         CMD_LOCK: begin
            adr = {`TWEECP_SUB_LOCK, 4'h0}; // [RULE4]
            prg = 1'b0;
         end
         CMD_ERASE_ALL: adr = {`TWEECP_SUB_ERASE_ALL, 4'h0};
         CMD_WRITE_ALL: begin
            adr = {`TWEECP_SUB_WRITE_ALL, 4'h0};
            tot = `TWEECP_RISES_WRITE;
         end
         default: prg = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // framing sequencer
   // ----------------------------------------------------------------
   always_comb begin
      next_h = h;
      next_h.rsp_valid = 1'b0;
      unique case (h.st)
         H_IDLE: begin
            if (cmd_valid) begin
               next_h.sh = {1'b1, opc, adr, cmd_data, 1'b0}; // [RULE1]
               next_h.sdata = 1'b1;
               next_h.cs = 1'b1;
               next_h.total = tot;
               next_h.rd = (cmd_op == CMD_READ);
               next_h.prog = prg;
               next_h.nb = 5'h00;
               next_h.div = 3'h0;
               next_h.st = H_SHIFT;
            end
         end
         H_SHIFT: begin
            next_h.div = h.div + 3'h1;
            if (h.div == `TWEECP_SHIFT_HALF - 3'h1) begin
               next_h.div = 3'h0;
               if (!h.shift_clk) begin
                  next_h.shift_clk = 1'b1;
                  next_h.nb = h.nb + 5'h01;
                  if (h.rd && h.nb >= `TWEECP_RD_FIRST) begin
                     next_h.rx = {h.rx[`TWEECP_DW-2:0], so_s};
                  end
               end else begin
                  // new data bit right after the falling edge
                  next_h.shift_clk = 1'b0;
                  next_h.sh = {h.sh[24:0], 1'b0};
                  next_h.sdata = h.sh[24];
                  if (h.nb == h.total) begin
                     next_h.cs = 1'b0;
                     next_h.sdata = 1'b0;
                     next_h.wcnt = 4'h0;
                     next_h.st = H_GAP;
                  end
               end
            end
         end
         H_GAP: begin
            next_h.wcnt = h.wcnt + 4'h1;
            if (h.wcnt == 4'(`TWEECP_CS_CYCLES - 1)) begin // [RULE11]
               next_h.wcnt = 4'h0;
               if (h.prog) begin
                  next_h.cs = 1'b1;
                  next_h.st = H_SETTLE;
               end else begin
                  next_h.rsp_valid = 1'b1;
                  next_h.rsp_data = h.rx;
                  next_h.st = H_IDLE;
               end
            end
         end
         H_SETTLE: begin
            // lets the status reach the pin before it is trusted
            next_h.wcnt = h.wcnt + 4'h1;
            if (h.wcnt == `TWEECP_SETTLE - 4'h1) begin
               next_h.st = H_POLL;
            end
         end
         H_POLL: begin
            if (so_s) begin // [RULE12]
               next_h.cs = 1'b0;
               next_h.prog = 1'b0;
               next_h.wcnt = 4'h0;
               next_h.st = H_GAP;
            end
         end
         default: next_h.st = H_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         h <= '0;
      end else begin
         h <= next_h;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign cmd_ready = (h.st == H_IDLE);
   assign link.cs = h.cs;
   assign link.shift_clock = h.shift_clk;
   assign link.serial_in = h.sdata;
   assign rsp_valid = h.rsp_valid;
   assign rsp_data = h.rsp_data;
endmodule : tweecp_host

// file: testbench/tweecp_sva.sv
/*
 * concurrent checks on the three-wire link between host end and eeprom end.
 * assumes instantiation beside the link interface, every signal by name.
 */
`timescale 1ns/1ps
`include "tweecp_consts.svh"
module tweecp_sva (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic cs,
   input wire logic shift_clock,
   input wire logic serial_in,
   input wire logic dout_oe,
   input wire logic serial_out,
   input wire logic busy,
   input wire logic unlocked
);
   logic shift_q;
   logic shift_rise;
   logic [4:0] cnt;
   logic [7:0] hdr;
   logic [1:0] op;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   // ----------------------------------------------------------------
   // frame tracking: link rises since select, header bits
   // ----------------------------------------------------------------
   assign shift_rise = shift_clock && !shift_q;
   assign op = hdr[6:5];
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         shift_q <= 1'b0;
         cnt <= 5'h00;
         hdr <= 8'h00;
      end else begin
         shift_q <= shift_clock;
         if (!cs) begin
            cnt <= 5'h00;
            hdr <= 8'h00;
         end else if (shift_rise) begin
            cnt <= cnt + 5'h01;
            if (cnt < 5'h08) begin
               hdr <= {hdr[6:0], serial_in};
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // sequences and assertions
   // ----------------------------------------------------------------
   sequence s_decode(logic [1:0] o);
      shift_rise && cnt == 5'h08 && op == o;
   endsequence
   sequence s_last_data;
      shift_rise && cnt == 5'h18 && op == `TWEECP_OP_WRITE;
   endsequence

   a_oe_off_unselected: assert property (!cs |-> !dout_oe)
      else $error("output driven while unselected");
   a_frame_start_bit: assert property (shift_rise && cnt == 5'h00 |-> serial_in)
      else $error("frame does not open with a one");
   a_read_dummy_zero: assert property (
      s_decode(`TWEECP_OP_READ) |-> dout_oe && !serial_out)
      else $error("read dummy bit missing");
   a_read_word_end: assert property (
      shift_rise && cnt == 5'h19 && op == `TWEECP_OP_READ |-> !dout_oe)
      else $error("read output not released after word");
   a_erase_busy_start: assert property (
      s_decode(`TWEECP_OP_ERASE) ##0 unlocked |-> ##[1:4] busy)
      else $error("erase did not start busy");
   a_write_busy_start: assert property (s_last_data ##0 unlocked |-> ##[1:4] busy)
      else $error("write did not start busy");
   a_locked_no_busy: assert property (
      s_decode(`TWEECP_OP_ERASE) ##0 (!unlocked && !busy) |-> ##1 !busy [*5])
      else $error("locked erase started busy");
   a_unlock_takes: assert property (
      s_decode(`TWEECP_OP_SPECIAL) ##0 (hdr[4:3] == 2'h3) |-> ##[0:2] unlocked)
      else $error("unlock not taken");
   a_status_busy_low: assert property (
      cs && cnt == 5'h00 && dout_oe && busy && $past(busy, 3) |-> !serial_out)
      else $error("status not low while busy");
   a_late_no_status: assert property (
      $rose(cs) && !busy |-> !dout_oe [*4])
      else $error("status shown after cycle ended");
   a_cs_low_gap: assert property ($fell(cs) |-> !cs [*3])
      else $error("select low gap too short");
   a_nine_clocks: assert property ($fell(cs) |-> cnt == 5'h00 || cnt >= 5'h09)
      else $error("frame with fewer than nine link clocks");
endmodule : tweecp_sva

// file: testbench/tweecp_tb.sv
/*
 * self-checking bench: host end and eeprom end joined by the link.
 * assumes design files compiled first; busy time shortened to 200 clocks.
 */
`timescale 1ns/1ps
`include "tweecp_consts.svh"
module tweecp_tb;
   import tweecp_pkg::*;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic cmd_valid = 1'b0;
   logic cmd_ready;
   tweecp_cmd_t cmd_op = CMD_READ;
   logic [5:0] cmd_addr = 6'h00;
   logic [15:0] cmd_data = 16'h0000;
   logic rsp_valid;
   logic [15:0] rsp_data;
   logic busy;
   logic unlocked;
   logic seen_busy = 1'b0;
   int err_total = 0;
   int cmp_count = 0;

   // ----------------------------------------------------------------
   // both ends, the link and its checker
   // ----------------------------------------------------------------
   tweecp_if u_tweecp_if();
   tweecp_host u_tweecp_host(.clock(clock), .rst_n(rst_n), .link(u_tweecp_if.host),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
      .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
   tweecp_device #(.WP_CYCLES(17'h000c8)) u_tweecp_device(.clock(clock), .rst_n(rst_n),
      .link(u_tweecp_if.dev), .busy(busy), .unlocked(unlocked));
   tweecp_sva u_tweecp_sva(.clock(clock), .rst_n(rst_n), .cs(u_tweecp_if.cs),
      .shift_clock(u_tweecp_if.shift_clock), .serial_in(u_tweecp_if.serial_in),
      .dout_oe(u_tweecp_if.dout_oe), .serial_out(u_tweecp_if.serial_out), .busy(busy),
      .unlocked(unlocked));

   // clock and busy monitor
   always #50 clock = ~clock;
   always @(posedge clock) begin
      if (busy === 1'b1) seen_busy <= 1'b1;
   end

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : conclude

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   // one command through the host port, bounded waits on ready and response
   task automatic issue(input tweecp_cmd_t op, input logic [5:0] a, input logic [15:0] d,
      output logic [15:0] q);
      int n;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 100) begin
         @(posedge clock);
         n++;
      end
      if (n >= 100) begin
         chk(16'h0000, 16'h0001, "host never ready");
         conclude();
      end
      cmd_valid <= 1'b1;
      cmd_op <= op;
      cmd_addr <= a;
      cmd_data <= d;
      @(posedge clock);
      cmd_valid <= 1'b0;
      n = 0;
      while (rsp_valid !== 1'b1 && n < 2000) begin
         @(posedge clock);
         n++;
      end
      if (n >= 2000) begin
         chk(16'h0000, 16'h0001, "no response");
         conclude();
      end
      q = rsp_data;
   endtask : issue

   task automatic rd(input logic [5:0] a, input logic [15:0] exp);
      logic [15:0] q;
      issue(CMD_READ, a, 16'h0000, q);
      chk(q, exp, "read word");
   endtask : rd

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   // locked after power-up: reads work, programming is ignored
   task automatic t_locked();
      logic [15:0] q;
      rd(6'h05, 16'h0000);
      issue(CMD_WRITE, 6'h05, 16'h5a5a, q);
      issue(CMD_ERASE, 6'h05, 16'h0000, q);
      rd(6'h05, 16'h0000);
      chk({15'h0000, unlocked}, 16'h0000, "locked at start");
      chk({15'h0000, seen_busy}, 16'h0000, "no busy while locked");
   endtask : t_locked

   // unlock, write both end words, erase one of them
   task automatic t_word();
      logic [15:0] q;
      time t0;
      issue(CMD_UNLOCK, 6'h00, 16'h0000, q);
      chk({15'h0000, unlocked}, 16'h0001, "unlock");
      issue(CMD_WRITE, 6'h00, 16'ha5c3, q);
      t0 = $time;
      issue(CMD_WRITE, 6'h3f, 16'h0001, q);
      // a write frame of 200 clocks plus 200 busy clocks must pass before ready
      chk({15'h0000, ($time - t0) > 64'h9c40}, 16'h0001, "ready before busy ended");
      chk({15'h0000, seen_busy}, 16'h0001, "busy cycle seen");
      rd(6'h00, 16'ha5c3);
      rd(6'h3f, 16'h0001);
      issue(CMD_ERASE, 6'h3f, 16'h0000, q);
      rd(6'h3f, `TWEECP_ERASED);
      rd(6'h00, 16'ha5c3);
   endtask : t_word

   // whole-array write then whole-array erase
   task automatic t_all();
      logic [15:0] q;
      issue(CMD_WRITE_ALL, 6'h00, 16'h1234, q);
      rd(6'h00, 16'h1234);
      rd(6'h25, 16'h1234);
      rd(6'h3f, 16'h1234);
      chk({15'h0000, unlocked}, 16'h0001, "still unlocked");
      issue(CMD_ERASE_ALL, 6'h00, 16'h0000, q);
      rd(6'h14, `TWEECP_ERASED);
   endtask : t_all

   // lock again: writes ignored, reads still fine
   task automatic t_lock();
      logic [15:0] q;
      issue(CMD_LOCK, 6'h00, 16'h0000, q);
      chk({15'h0000, unlocked}, 16'h0000, "lock");
      issue(CMD_WRITE, 6'h14, 16'h0000, q);
      rd(6'h14, `TWEECP_ERASED);
   endtask : t_lock

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      t_locked();
      t_word();
      t_all();
      t_lock();
      conclude();
   end
endmodule : tweecp_tb
